// ### common/bit_pkg.sv
// Constants for the basic interval timer: register map, field layout, reset values.
// Contract
// RULE_01: Counter built 16 or 32 bits wide.
// RULE_02: Counter clocked from core clock via prescaler.
// RULE_03: Prescale bits in control register set resolution.
// RULE_04: System reset returns everything to defaults.
// RULE_05: Soft reset bit produces internal full reset.
// RULE_06: Effective reset is system OR soft reset.
// RULE_07: Limit sets status; interrupt when enabled.
// RULE_08: Low-power request accepted only when inactive.
// RULE_09: Sleep-capable when disabled, stopped or halted.
// RULE_10: Active while start set, unless sleep-capable.
// RULE_11: Counter counts up or down.
// RULE_12: One-shot stops at limit, level event.
// RULE_13: Continuous reloads preload, single-cycle pulse event.
// RULE_14: Control register reloads, halts or starts counter.
// RULE_15: Hardware updates count; firmware may write it.
// RULE_16: Count reads come from buffered consistent copy.
// RULE_17: Upper count bits read zero in narrow instance.
// RULE_18: Five registers at offsets 00h to 10h.
// RULE_19: No external pins; internal host port only.
// RULE_20: Restart loads preload; preload is counter width.
// RULE_21: One count enable per setting plus one clocks.
// RULE_22: Interrupt enable bit gates status onto interrupt.
// RULE_23: Limit is all-ones up, zero down.
package bit_pkg;
  localparam logic [4:0]  BIT_OFS_COUNT     = 5'h00;
  localparam logic [4:0]  BIT_OFS_PRELOAD   = 5'h04;
  localparam logic [4:0]  BIT_OFS_STATUS    = 5'h08;
  localparam logic [4:0]  BIT_OFS_IRQ_EN    = 5'h0c;
  localparam logic [4:0]  BIT_OFS_SETTINGS  = 5'h10;
  localparam int          BIT_CTL_ENABLE    = 0;
  localparam int          BIT_CTL_COUNT_UP  = 2;
  localparam int          BIT_CTL_AUTO      = 3;
  localparam int          BIT_CTL_SOFT_RST  = 4;
  localparam int          BIT_CTL_START     = 5;
  localparam int          BIT_CTL_RELOAD    = 6;
  localparam int          BIT_CTL_HALT      = 7;
  localparam int          BIT_CTL_PSC_LSB   = 16;
  localparam int          BIT_PSC_W         = 16;
  localparam int          BIT_STAT_EVENT    = 0;
  localparam int          BIT_IRQ_EN_EVENT  = 0;
  localparam logic [31:0] BIT_COUNT_RST     = 32'h0000_0000;
  localparam logic [31:0] BIT_PRELOAD_RST   = 32'h0000_0000;
  localparam logic [31:0] BIT_SETTINGS_RST  = 32'h0000_0000;
  localparam logic [15:0] BIT_PSC_RST       = 16'h0000;
endpackage

// ### rtl/bit_prescaler.sv
// Clock-enable divider: one tick every (div + 1) clocks.
`timescale 1ns/1ps
module bit_prescaler (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] div,
  output logic             tick
);
  logic [15:0] cnt;
  wire         wrap = (cnt >= div);

  // Restarts from zero whenever stopped, so the first tick is a full period away
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? 16'h0000 : cnt + 16'h0001; // see RULE_21
      tick <= wrap;
    end
  end
endmodule

// ### rtl/bit_timer.sv
// Basic interval timer: host registers, counter, events and low-power handshake.
`timescale 1ns/1ps
module bit_timer #(
  parameter int CNT_W = 32 // see RULE_01
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        host_sel,
  input  wire logic        host_wr,
  input  wire logic [4:0]  host_addr,
  input  wire logic [3:0]  host_be,
  input  wire logic [31:0] host_wdata,
  output logic [31:0]      host_rdata,
  output logic             host_rvalid,
  input  wire logic        lp_req,
  output logic             lp_ack,
  output logic             sleep_capable,
  output logic             irq_out
);
  logic             soft_rst;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] preload;
  logic [31:0]      count_shadow;
  logic             status;
  logic             irq_en;
  logic             enable;
  logic             count_up;
  logic             auto_rs;
  logic             start;
  logic             halt;
  logic [15:0]      psc;
  logic             tick;

  localparam logic [CNT_W-1:0] LIM_UP   = '1;
  localparam logic [CNT_W-1:0] LIM_DOWN = '0;

  // Soft reset lasts exactly one clock: it clears its own flop
  wire timer_rst = !rst_n || soft_rst; // see RULE_04 see RULE_06

  // Host port decode; internal port only, no pins leave the block
  wire        wr_en     = host_sel && host_wr; // see RULE_19
  wire        rd_en     = host_sel && !host_wr;
  wire        hit_count = (host_addr == bit_pkg::BIT_OFS_COUNT); // see RULE_18
  wire        hit_pre   = (host_addr == bit_pkg::BIT_OFS_PRELOAD);
  wire        hit_stat  = (host_addr == bit_pkg::BIT_OFS_STATUS);
  wire        hit_ien   = (host_addr == bit_pkg::BIT_OFS_IRQ_EN);
  wire        hit_ctl   = (host_addr == bit_pkg::BIT_OFS_SETTINGS);
  wire [31:0] bmask     = {{8{host_be[3]}}, {8{host_be[2]}}, {8{host_be[1]}}, {8{host_be[0]}}};

  wire [31:0] cnt32     = 32'(count);
  wire [31:0] pre32     = 32'(preload);
  wire [31:0] cnt_merge = (cnt32 & ~bmask) | (host_wdata & bmask);
  wire [31:0] pre_merge = (pre32 & ~bmask) | (host_wdata & bmask);

  wire        cnt_wr    = wr_en && hit_count;
  wire        ctl_lo_wr = wr_en && hit_ctl && host_be[0];
  wire        ctl_hi_wr = wr_en && hit_ctl && host_be[2] && host_be[3];
  wire        soft_wr   = ctl_lo_wr && host_wdata[bit_pkg::BIT_CTL_SOFT_RST];
  wire        reload_wr = ctl_lo_wr && host_wdata[bit_pkg::BIT_CTL_RELOAD];
  wire        stat_clr  = wr_en && hit_stat && host_be[0] &&
                          host_wdata[bit_pkg::BIT_STAT_EVENT];

  // Counting engine
  wire             running  = enable && start && !halt;
  wire             step_en  = running && tick;
  wire [CNT_W-1:0] limit    = count_up ? LIM_UP : LIM_DOWN; // see RULE_23
  wire [CNT_W-1:0] stepped  = count_up ? count + CNT_W'(1) : count - CNT_W'(1); // see RULE_11
  wire             hit_lim  = step_en && (stepped == limit);
  wire             sleep_ok = !enable || !start || halt; // see RULE_09

  wire [31:0] ctl_rd = {psc, 8'h00, halt, 1'b0, start, 1'b0, auto_rs, count_up, 1'b0, enable};

  wire [31:0] read_val =
      hit_count ? (host_be[0] ? cnt32 : count_shadow) :
      hit_pre   ? pre32 :
      hit_stat  ? {31'h0, status} :
      hit_ien   ? {31'h0, irq_en} :
      hit_ctl   ? ctl_rd : 32'h0000_0000;

  bit_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .rst     (timer_rst),
    .run     (running),
    .div     (psc),
    .tick    (tick)
  ); // see RULE_02

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= !soft_rst && soft_wr; // see RULE_05
    end
  end

  // Firmware write wins over hardware; writing while running is undefined by design
  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      count <= CNT_W'(bit_pkg::BIT_COUNT_RST);
    end else if (cnt_wr) begin
      count <= CNT_W'(cnt_merge); // see RULE_15 see RULE_17
    end else if (reload_wr) begin
      count <= preload; // see RULE_14
    end else if (step_en) begin
      count <= (hit_lim && auto_rs) ? preload : stepped; // see RULE_13 see RULE_20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      preload <= CNT_W'(bit_pkg::BIT_PRELOAD_RST);
    end else if (wr_en && hit_pre) begin
      preload <= CNT_W'(pre_merge); // see RULE_20
    end
  end

  // Byte-lane 0 read freezes the count for the remaining byte reads
  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      count_shadow <= 32'h0000_0000;
    end else if (rd_en && hit_count && host_be[0]) begin
      count_shadow <= cnt32; // see RULE_16
    end
  end

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      enable   <= bit_pkg::BIT_SETTINGS_RST[bit_pkg::BIT_CTL_ENABLE];
      count_up <= bit_pkg::BIT_SETTINGS_RST[bit_pkg::BIT_CTL_COUNT_UP];
      auto_rs  <= bit_pkg::BIT_SETTINGS_RST[bit_pkg::BIT_CTL_AUTO];
      halt     <= bit_pkg::BIT_SETTINGS_RST[bit_pkg::BIT_CTL_HALT];
    end else if (ctl_lo_wr) begin
      enable   <= host_wdata[bit_pkg::BIT_CTL_ENABLE];
      count_up <= host_wdata[bit_pkg::BIT_CTL_COUNT_UP]; // see RULE_11
      auto_rs  <= host_wdata[bit_pkg::BIT_CTL_AUTO];
      halt     <= host_wdata[bit_pkg::BIT_CTL_HALT]; // see RULE_14
    end
  end

  // One-shot stop clears start; a firmware write in the same clock wins
  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      start <= bit_pkg::BIT_SETTINGS_RST[bit_pkg::BIT_CTL_START];
    end else if (ctl_lo_wr) begin
      start <= host_wdata[bit_pkg::BIT_CTL_START]; // see RULE_14
    end else if (hit_lim && !auto_rs) begin
      start <= 1'b0; // see RULE_12
    end
  end

  // Divider restarts on stop, so a new setting takes effect cleanly after a halt
  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      psc <= bit_pkg::BIT_PSC_RST;
    end else if (ctl_hi_wr) begin
      psc <= host_wdata[bit_pkg::BIT_CTL_PSC_LSB +: bit_pkg::BIT_PSC_W]; // see RULE_03
    end
  end

  // Level in one-shot, one-clock pulse in continuous; a new event beats a clear
  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      status <= 1'b0;
    end else if (hit_lim) begin
      status <= 1'b1; // see RULE_07
    end else if (auto_rs || stat_clr) begin
      status <= 1'b0; // see RULE_12 see RULE_13
    end
  end

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      irq_en <= 1'b0;
    end else if (wr_en && hit_ien && host_be[0]) begin
      irq_en <= host_wdata[bit_pkg::BIT_IRQ_EN_EVENT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= status && irq_en; // see RULE_07 see RULE_22
    end
  end

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      host_rdata  <= 32'h0000_0000;
      host_rvalid <= 1'b0;
    end else begin
      host_rdata  <= rd_en ? read_val : 32'h0000_0000; // see RULE_17
      host_rvalid <= rd_en;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      sleep_capable <= 1'b1;
      lp_ack        <= 1'b0;
    end else begin
      sleep_capable <= sleep_ok; // see RULE_09 see RULE_10
      lp_ack        <= lp_req && sleep_ok; // see RULE_08
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (timer_rst);

  // Checker-only record of what the host saw on its last lane-0 count read
  logic        chk_lane0;
  logic        chk_lane1;
  logic [31:0] chk_first;

  always_ff @(posedge sys_clk) begin
    if (timer_rst) begin
      chk_lane0 <= 1'b0;
      chk_lane1 <= 1'b0;
      chk_first <= 32'h0000_0000;
    end else begin
      chk_lane0 <= rd_en && hit_count && host_be[0];
      chk_lane1 <= rd_en && hit_count && !host_be[0];
      if (chk_lane0) begin
        chk_first <= host_rdata;
      end
    end
  end

  sequence s_limit_oneshot;
    hit_lim && !auto_rs && !ctl_lo_wr && !cnt_wr;
  endsequence

  sequence s_limit_cont;
    hit_lim && auto_rs && !cnt_wr && !reload_wr && !ctl_lo_wr;
  endsequence

  sequence s_shadow_pair;
    (rd_en && hit_count && host_be[0]) ##1 (rd_en && hit_count && !host_be[0]);
  endsequence

  a_irq_from_status: assert property ( // see RULE_07
    (status && irq_en) |=> irq_out)
    else $error("irq not raised from enabled status");

  a_irq_gate_enable: assert property ( // see RULE_22
    irq_out |-> $past(irq_en) && $past(status))
    else $error("irq raised without enable or status");

  a_oneshot_stop: assert property ( // see RULE_12
    s_limit_oneshot |=> (!start && status && count == limit) ##1 (status || $past(stat_clr)))
    else $error("one-shot did not stop with held event");

  a_cont_reload: assert property ( // see RULE_13
    s_limit_cont |=> (status && count == $past(preload)) ##1 (!status || $past(hit_lim)))
    else $error("continuous restart or pulse wrong");

  a_sleep_report: assert property ( // see RULE_09
    (!enable || !start || halt) |=> sleep_capable)
    else $error("sleep-capable not reported");

  a_active_no_ack: assert property ( // see RULE_08
    (running && !ctl_lo_wr) [*2] |=> !lp_ack && !sleep_capable)
    else $error("low-power accepted while active");

  a_prescale_gap: assert property ( // see RULE_21
    (tick && running && psc == 16'h0001) ##1 (running && psc == 16'h0001) |-> !tick ##1 tick)
    else $error("prescaler period wrong for setting one");

  a_buffered_read: assert property ( // see RULE_16
    s_shadow_pair |=> host_rdata == $past(cnt32, 2))
    else $error("buffered count read inconsistent");

  a_narrow_upper: assert property ( // see RULE_17
    (CNT_W < 32) && host_rvalid |-> host_rdata[31:16] == 16'h0000 || !$past(hit_count))
    else $error("upper count bits not zero");

  a_soft_reset: assert property ( // see RULE_05
    @(posedge sys_clk) disable iff (!rst_n)
    soft_wr && !soft_rst |=> soft_rst ##1 (!soft_rst && count == '0 && !start && !status))
    else $error("soft reset did not clear the block");

  a_shadow_bytes: assert property ( // see RULE_16
    chk_lane1 |-> host_rdata == chk_first)
    else $error("byte read not from the buffered count");

  a_read_answer: assert property ( // see RULE_19
    rd_en |=> host_rvalid)
    else $error("read not answered next cycle");

  a_idle_quiet: assert property ( // see RULE_19
    !rd_en |=> !host_rvalid && host_rdata == 32'h0000_0000)
    else $error("read data or valid without a read");

  a_unmapped_zero: assert property ( // see RULE_18
    rd_en && !(hit_count || hit_pre || hit_stat || hit_ien || hit_ctl) |=>
      host_rdata == 32'h0000_0000)
    else $error("unmapped offset did not read zero");

  a_preload_upper: assert property ( // see RULE_20
    (CNT_W < 32) && rd_en && hit_pre |=> host_rdata[31:16] == 16'h0000)
    else $error("upper preload bits not zero");

  a_count_up: assert property ( // see RULE_11
    step_en && count_up && !hit_lim && !cnt_wr && !reload_wr |=> count == $past(count) + CNT_W'(1))
    else $error("up count step wrong");

  a_count_down: assert property ( // see RULE_11
    step_en && !count_up && !hit_lim && !cnt_wr && !reload_wr |=> count == $past(count) - CNT_W'(1))
    else $error("down count step wrong");

  a_halt_freeze: assert property ( // see RULE_14
    halt && !cnt_wr && !reload_wr |=> count == $past(count))
    else $error("count moved while halted");

  a_reload_load: assert property ( // see RULE_14
    reload_wr |=> count == $past(preload))
    else $error("reload strobe did not load preload");

  a_event_held: assert property ( // see RULE_12
    status && !auto_rs && !stat_clr |=> status)
    else $error("one-shot event not held");

  a_event_pulse: assert property ( // see RULE_13
    status && auto_rs && !hit_lim |=> !status)
    else $error("continuous event longer than one clock");

  a_tick_full: assert property ( // see RULE_21
    running && psc == 16'h0000 |=> tick)
    else $error("setting zero not at full speed");

  a_tick_idle: assert property ( // see RULE_21
    !running |=> !tick)
    else $error("count enable while stopped");

  a_lp_grant: assert property ( // see RULE_08
    lp_req && sleep_ok |=> lp_ack)
    else $error("low-power request refused while idle");

  a_sleep_active: assert property ( // see RULE_10
    running |=> !sleep_capable)
    else $error("sleep-capable while running");

  a_irq_masked: assert property ( // see RULE_22
    !irq_en |=> !irq_out)
    else $error("irq raised while disabled");

  a_soft_pulse: assert property ( // see RULE_05
    @(posedge sys_clk) disable iff (!rst_n)
    soft_rst |=> !soft_rst)
    else $error("soft reset lasted more than one clock");
endmodule

// ### tb/bit_testbench.sv
// Self-checking bench for the basic interval timer, 16-bit instance.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] EN    = 32'h1 << bit_pkg::BIT_CTL_ENABLE;
  localparam logic [31:0] UP    = 32'h1 << bit_pkg::BIT_CTL_COUNT_UP;
  localparam logic [31:0] AUTO  = 32'h1 << bit_pkg::BIT_CTL_AUTO;
  localparam logic [31:0] SRST  = 32'h1 << bit_pkg::BIT_CTL_SOFT_RST;
  localparam logic [31:0] START = 32'h1 << bit_pkg::BIT_CTL_START;
  localparam logic [31:0] RLD   = 32'h1 << bit_pkg::BIT_CTL_RELOAD;
  localparam logic [31:0] HALT  = 32'h1 << bit_pkg::BIT_CTL_HALT;
  localparam logic [31:0] PSC1  = 32'h1 << bit_pkg::BIT_CTL_PSC_LSB;
  logic        sys_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        host_sel   = 1'b0;
  logic        host_wr    = 1'b0;
  logic [4:0]  host_addr  = 5'h00;
  logic [3:0]  host_be    = 4'h0;
  logic [31:0] host_wdata = 32'h0;
  logic        lp_req     = 1'b0;
  wire  logic [31:0] host_rdata;
  wire  logic        host_rvalid;
  wire  logic        lp_ack;
  wire  logic        sleep_capable;
  wire  logic        irq_out;
  int          err_count   = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          t0;
  logic [31:0] snap;
  logic [31:0] v;

  bit_timer #(.CNT_W(16)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .host_sel(host_sel), .host_wr(host_wr),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .lp_req(lp_req),
    .lp_ack(lp_ack), .sleep_capable(sleep_capable), .irq_out(irq_out)
  );

  always #2.5 sys_clk = ~sys_clk;

  // Run needs well under 1000 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [3:0] be, input logic [31:0] d);
    step(1);
    host_sel = 1'b1; host_wr = 1'b1; host_addr = a; host_be = be; host_wdata = d;
    step(1);
    host_sel = 1'b0; host_wr = 1'b0;
  endtask

  // Answer stands for the one cycle after the taking edge only
  task automatic rd(input logic [4:0] a, input logic [3:0] be, output logic [31:0] d);
    step(1);
    host_sel = 1'b1; host_wr = 1'b0; host_addr = a; host_be = be;
    step(1);
    host_sel = 1'b0;
    check({31'h0, host_rvalid}, 32'h1, "read valid");
    d = host_rdata;
  endtask

  // Lane 0 then lane 1 in consecutive cycles, as a byte-wide host would
  task automatic rd_pair(output logic [31:0] d0, output logic [31:0] d1);
    step(1);
    host_sel = 1'b1;
    host_wr = 1'b0;
    host_addr = bit_pkg::BIT_OFS_COUNT;
    host_be = 4'h1;
    step(1);
    host_be = 4'h2;
    check({31'h0, host_rvalid}, 32'h1, "pair valid lane 0");
    d0 = host_rdata;
    step(1);
    host_sel = 1'b0;
    check({31'h0, host_rvalid}, 32'h1, "pair valid lane 1");
    d1 = host_rdata;
  endtask

  // Bounded wait so a dead event never hangs the run
  task automatic wait_irq(input logic lvl);
    int i;
    i = 0;
    while (irq_out !== lvl && i < 50) begin
      step(1);
      i++;
    end
  endtask

  initial begin
    step(10);
    rst_n = 1'b1;
    for (int a = 0; a <= 20; a += 4) begin
      rd(a[4:0], 4'hf, v);
      check(v, 32'h0, "reset value");
    end
    check({31'h0, sleep_capable}, 32'h1, "idle sleep");
    $display("test reset done");
    wr(bit_pkg::BIT_OFS_COUNT, 4'hf, 32'hffff_1234);
    rd(bit_pkg::BIT_OFS_COUNT, 4'hf, v);
    check(v, 32'h0000_1234, "count width");
    wr(bit_pkg::BIT_OFS_PRELOAD, 4'hf, 32'habcd_5678);
    rd(bit_pkg::BIT_OFS_PRELOAD, 4'hf, v);
    check(v, 32'h0000_5678, "preload width");
    $display("test width done");
    // One-shot up with interrupt masked, then unmasked
    wr(bit_pkg::BIT_OFS_COUNT, 4'hf, 32'h0000_fffd);
    wr(bit_pkg::BIT_OFS_SETTINGS, 4'hf, EN | UP | START);
    step(10);
    rd(bit_pkg::BIT_OFS_COUNT, 4'hf, v);
    check(v, 32'h0000_ffff, "stop at top");
    rd(bit_pkg::BIT_OFS_STATUS, 4'hf, v);
    check(v, 32'h1, "status set");
    check({31'h0, irq_out}, 32'h0, "masked irq");
    rd(bit_pkg::BIT_OFS_SETTINGS, 4'hf, v);
    check(v, EN | UP, "start cleared");
    check({31'h0, sleep_capable}, 32'h1, "stopped sleep");
    wr(bit_pkg::BIT_OFS_IRQ_EN, 4'hf, 32'h1);
    step(8);
    check({31'h0, irq_out}, 32'h1, "level irq");
    wr(bit_pkg::BIT_OFS_STATUS, 4'hf, 32'h1);
    step(2);
    check({31'h0, irq_out}, 32'h0, "irq cleared");
    rd(bit_pkg::BIT_OFS_STATUS, 4'hf, v);
    check(v, 32'h0, "status cleared");
    $display("test one-shot done");
    // Continuous down, prescale 1, preload 3: the step into zero reloads, so 3 * 2 clocks
    wr(bit_pkg::BIT_OFS_PRELOAD, 4'hf, 32'h3);
    wr(bit_pkg::BIT_OFS_COUNT, 4'hf, 32'h2);
    lp_req = 1'b1;
    wr(bit_pkg::BIT_OFS_SETTINGS, 4'hf, EN | AUTO | START | PSC1);
    step(2);
    check({31'h0, sleep_capable}, 32'h0, "running active");
    check({31'h0, lp_ack}, 32'h0, "lp refused");
    wait_irq(1'b1);
    t0 = cycles;
    wait_irq(1'b0);
    check(cycles - t0, 32'd1, "pulse width");
    wait_irq(1'b1);
    check(cycles - t0, 32'd6, "event period");
    rd(bit_pkg::BIT_OFS_COUNT, 4'h1, snap);
    step(3);
    rd(bit_pkg::BIT_OFS_COUNT, 4'h2, v);
    check(v, snap, "shadow copy");
    rd_pair(snap, v);
    check(v, snap, "byte pair");
    wr(bit_pkg::BIT_OFS_SETTINGS, 4'hf, EN | AUTO | START | HALT | PSC1);
    step(2);
    check({31'h0, sleep_capable}, 32'h1, "halted sleep");
    check({31'h0, lp_ack}, 32'h1, "lp granted");
    rd(bit_pkg::BIT_OFS_COUNT, 4'hf, snap);
    step(6);
    rd(bit_pkg::BIT_OFS_COUNT, 4'hf, v);
    check(v, snap, "halt holds");
    wr(bit_pkg::BIT_OFS_SETTINGS, 4'hf, EN | AUTO | START | HALT | RLD | PSC1);
    rd(bit_pkg::BIT_OFS_COUNT, 4'hf, v);
    check(v, 32'h3, "reload strobe");
    $display("test continuous done");
    // Soft reset via low byte only
    wr(bit_pkg::BIT_OFS_SETTINGS, 4'h1, SRST);
    step(2);
    for (int a = 0; a <= 16; a += 4) begin
      rd(a[4:0], 4'hf, v);
      check(v, 32'h0, "soft reset");
    end
    lp_req = 1'b0;
    $display("test soft reset done");
    wr(bit_pkg::BIT_OFS_PRELOAD, 4'hf, 32'h7);
    wr(bit_pkg::BIT_OFS_SETTINGS, 4'hf, EN | UP | START);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    rd(bit_pkg::BIT_OFS_PRELOAD, 4'hf, v);
    check(v, 32'h0, "system reset");
    rd(bit_pkg::BIT_OFS_SETTINGS, 4'hf, v);
    check(v, 32'h0, "system reset ctl");
    $display("test system reset done");
    wrap_up();
  end
endmodule
